// *** src/swl_link.sv ***
// sensor-side time-slot engine of the single-wire open-drain data line
// assumes the wire level is resolved outside; the line pin is asynchronous
`timescale 1ns/1ps
// How it works
// - sensor samples the line 15 to 60 us after the falling edge
// - sensor transmits only in read slots after BEh, B4h, 44h or B8h
// - sensor sends one by releasing, zero by pulling low, released by slot end
// - sensor read data stays valid 15 us after the falling edge
// - 480 us low is reset; sensor waits 15-60 us, presence 60-240 us
// - each slot carries exactly one bit
// - status read slots answer zero while busy, one when done
module swl_link
    import swl_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic SRST,
    input wire logic DQ_IN,
    output logic DQ_OUT,
    output logic DQ_OE,
    input wire logic PARASITE,
    input wire logic OP_BUSY,
    input wire logic [7:0] TX_BYTE,
    output logic TX_NEXT,
    output logic [7:0] RX_BYTE,
    output logic RX_VALID,
    output logic [7:0] CMD_BYTE,
    output logic CMD_VALID,
    output logic LINK_RESET
);
    typedef enum logic [2:0] {ST_IDLE, ST_SLOT, ST_WAIT_HIGH, ST_PRES_WAIT, ST_PRES} swl_state_t;

    logic line;
    swl_state_t state_reg, state_next;
    swl_mode_t mode_reg, mode_next;
    logic [CW-1:0] cnt_reg, cnt_next;
    logic [CW-1:0] low_reg, low_next;
    logic line_d_reg, line_d_next;
    logic [7:0] sh_reg, sh_next;
    logic [2:0] bit_reg, bit_next;
    logic [3:0] bytes_reg, bytes_next;
    logic [7:0] tx_reg, tx_next;
    logic tx_bit_next;
    logic drive_reg, drive_next;
    logic [7:0] rx_reg, rx_next;
    logic rx_v_reg, rx_v_next;
    logic [7:0] cmd_reg, cmd_next;
    logic cmd_v_reg, cmd_v_next;
    logic txn_reg, txn_next;
    logic rst_reg, rst_next;

    swl_sync u_sync (
        .clk(CORE_CLK),
        .srst(SRST),
        .d(DQ_IN),
        .q(line)
    );

    function automatic logic is_read_mode(input swl_mode_t m);
        is_read_mode = (m != MODE_CMD);
    endfunction : is_read_mode

    always_comb begin
        state_next = state_reg;
        mode_next = mode_reg;
        cnt_next = (cnt_reg == '1) ? cnt_reg : cnt_reg + 1'b1;
        low_next = line ? '0 : ((low_reg == '1) ? low_reg : low_reg + 1'b1);
        line_d_next = line;
        sh_next = sh_reg;
        bit_next = bit_reg;
        bytes_next = bytes_reg;
        tx_next = tx_reg;
        tx_bit_next = 1'b1;
        drive_next = drive_reg;
        rx_next = rx_reg;
        rx_v_next = 1'b0;
        cmd_next = cmd_reg;
        cmd_v_next = 1'b0;
        txn_next = 1'b0;
        rst_next = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                drive_next = 1'b0;
                if (line_d_reg && !line) begin
                    state_next = ST_SLOT;
                    cnt_next = '0;
                    // choose the bit to send before the master releases
                    case (mode_reg)
                        MODE_DATA: tx_bit_next = tx_reg[bit_reg];
                        MODE_STATUS: tx_bit_next = !OP_BUSY;
                        MODE_SUPPLY: tx_bit_next = !PARASITE;
                        default: tx_bit_next = 1'b1;
                    endcase
                    // read answers only in read modes
                    drive_next = is_read_mode(mode_reg) && !tx_bit_next;
                end
            end
            ST_SLOT: begin
                // release our low once the valid window ends
                if (cnt_reg == READ_HOLD_CYC) begin
                    drive_next = 1'b0;
                end
                if (cnt_reg == SAMPLE_CYC) begin
                    state_next = ST_WAIT_HIGH;
                    if (mode_reg == MODE_CMD) begin
                        sh_next = {line, sh_reg[7:1]};
                        bit_next = bit_reg + 1'b1;
                        if (bit_reg == 3'd7) begin
                            cmd_next = {line, sh_reg[7:1]};
                            cmd_v_next = 1'b1;
                            case ({line, sh_reg[7:1]})
                                CMD_READ_SCRATCH: begin
                                    mode_next = MODE_DATA;
                                    bytes_next = '0;
                                    tx_next = TX_BYTE;
                                    txn_next = 1'b1;
                                end
                                CMD_READ_SUPPLY: mode_next = MODE_SUPPLY;
                                CMD_CONVERT: mode_next = MODE_STATUS;
                                CMD_RESTORE: mode_next = MODE_STATUS;
                                default: mode_next = MODE_CMD;
                            endcase
                        end
                    end else if (mode_reg == MODE_DATA) begin
                        bit_next = bit_reg + 1'b1;
                        if (bit_reg == 3'd7) begin
                            rx_next = tx_reg;
                            rx_v_next = 1'b1;
                            bytes_next = bytes_reg + 1'b1;
                            if (bytes_reg + 1'b1 == SCRATCH_BYTES) begin
                                mode_next = MODE_CMD;
                            end else begin
                                tx_next = TX_BYTE;
                                txn_next = 1'b1;
                            end
                        end
                    end
                end
            end
            ST_WAIT_HIGH: begin
                if (cnt_reg >= READ_HOLD_CYC) begin
                    drive_next = 1'b0;
                end
                if (line) begin
                    state_next = ST_IDLE;
                end
            end
            ST_PRES_WAIT: begin
                if (cnt_reg == PRES_WAIT_CYC) begin
                    state_next = ST_PRES;
                    cnt_next = '0;
                    drive_next = 1'b1;
                end
            end
            ST_PRES: begin
                if (cnt_reg == PRES_LEN_CYC) begin
                    state_next = ST_IDLE;
                    drive_next = 1'b0;
                end
            end
            default: state_next = ST_IDLE;
        endcase
        // a reset-length low overrides any slot in progress
        if (!drive_reg && low_reg >= RESET_CYC) begin
            state_next = ST_WAIT_HIGH;
            mode_next = MODE_CMD;
            bit_next = '0;
            bytes_next = '0;
            drive_next = 1'b0;
            rst_next = 1'b1;
        end
        // release edge after a reset pulse starts presence timing
        if (!drive_reg && low_reg >= RESET_CYC && line) begin
            state_next = ST_PRES_WAIT;
            cnt_next = '0;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            state_reg <= ST_IDLE;
            mode_reg <= MODE_CMD;
            cnt_reg <= '0;
            low_reg <= '0;
            line_d_reg <= 1'b1;
            sh_reg <= '0;
            bit_reg <= '0;
            bytes_reg <= '0;
            tx_reg <= '0;
            drive_reg <= 1'b0;
            rx_reg <= '0;
            rx_v_reg <= 1'b0;
            cmd_reg <= '0;
            cmd_v_reg <= 1'b0;
            txn_reg <= 1'b0;
            rst_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            mode_reg <= mode_next;
            cnt_reg <= cnt_next;
            low_reg <= low_next;
            line_d_reg <= line_d_next;
            sh_reg <= sh_next;
            bit_reg <= bit_next;
            bytes_reg <= bytes_next;
            tx_reg <= tx_next;
            drive_reg <= drive_next;
            rx_reg <= rx_next;
            rx_v_reg <= rx_v_next;
            cmd_reg <= cmd_next;
            cmd_v_reg <= cmd_v_next;
            txn_reg <= txn_next;
            rst_reg <= rst_next;
        end
    end

    // open drain: only ever drive low
    assign DQ_OUT = 1'b0;
    assign DQ_OE = drive_reg;
    assign TX_NEXT = txn_reg;
    assign RX_BYTE = rx_reg;
    assign RX_VALID = rx_v_reg;
    assign CMD_BYTE = cmd_reg;
    assign CMD_VALID = cmd_v_reg;
    assign LINK_RESET = rst_reg;
endmodule : swl_link

// *** pkg/swl_pkg.sv ***
// constants for the single-wire time-slot engine (sensor side)
// assumes a 40 MHz core clock; all counts are derived from printed times
package swl_pkg;
    localparam int unsigned CLK_MHZ = 40;
    localparam int unsigned CW = 16;
    // slot timing, microseconds as printed
    localparam int unsigned SAMPLE_MIN_US = 15;
    localparam int unsigned SAMPLE_MAX_US = 60;
    localparam int unsigned READ_VALID_US = 15;
    localparam int unsigned RESET_MIN_US = 480;
    localparam int unsigned PRES_WAIT_US = 15;
    localparam int unsigned PRES_LEN_US = 60;
    // sample at 30 us, inside the 15 to 60 us window
    localparam int unsigned SAMPLE_AT_US = 30;
    // derived counts in core cycles
    localparam logic [CW-1:0] SAMPLE_CYC = CW'(SAMPLE_AT_US * CLK_MHZ);
    localparam logic [CW-1:0] READ_HOLD_CYC = CW'(READ_VALID_US * CLK_MHZ);
    localparam logic [CW-1:0] RESET_CYC = CW'(RESET_MIN_US * CLK_MHZ);
    localparam logic [CW-1:0] PRES_WAIT_CYC = CW'(PRES_WAIT_US * CLK_MHZ);
    localparam logic [CW-1:0] PRES_LEN_CYC = CW'(PRES_LEN_US * CLK_MHZ);
    // function command codes
    localparam logic [7:0] CMD_CONVERT = 8'h44;
    localparam logic [7:0] CMD_READ_SCRATCH = 8'hBE;
    localparam logic [7:0] CMD_READ_SUPPLY = 8'hB4;
    localparam logic [7:0] CMD_RESTORE = 8'hB8;
    localparam logic [3:0] SCRATCH_BYTES = 4'h9;
    typedef enum logic [1:0] {MODE_CMD, MODE_DATA, MODE_STATUS, MODE_SUPPLY} swl_mode_t;
endpackage : swl_pkg

// *** src/swl_sync.sv ***
// two-flop synchroniser for the line level
// assumes a free-running core clock
`timescale 1ns/1ps
module swl_sync
    import swl_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic d,
    output logic q
);
    logic s1_reg;
    logic s2_reg;
    logic s1_next;
    logic s2_next;
    always_comb begin
        s1_next = d;
        s2_next = s1_reg;
    end
    // reset to released (high) level
    always_ff @(posedge clk) begin
        if (srst) begin
            s1_reg <= 1'b1;
            s2_reg <= 1'b1;
        end else begin
            s1_reg <= s1_next;
            s2_reg <= s2_next;
        end
    end
    assign q = s2_reg;
endmodule : swl_sync

// *** verif/swl_link_checker.sv ***
// checker for the sensor-side slot engine, sees top ports only
// assumes the wire level reaches DQ_IN already resolved with a pull-up
`timescale 1ns/1ps
module swl_link_checker (
    input wire logic CORE_CLK,
    input wire logic SRST,
    input wire logic DQ_IN,
    input wire logic DQ_OUT,
    input wire logic DQ_OE,
    input wire logic RX_VALID,
    input wire logic CMD_VALID,
    input wire logic LINK_RESET
);
    logic [15:0] low_reg, low_next, high_reg, high_next, oe_reg, oe_next;
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (SRST);
    // raw line counters lead the synchronised view by a few cycles
    always_comb begin
        low_next = DQ_IN ? 16'h0000 : low_reg + {15'h0000, low_reg != 16'hFFFF};
        high_next = !DQ_IN ? 16'h0000 : high_reg + {15'h0000, high_reg != 16'hFFFF};
        oe_next = DQ_OE ? oe_reg + 16'h0001 : 16'h0000;
    end
    always_ff @(posedge CORE_CLK) begin
        low_reg <= SRST ? 16'h0000 : low_next;
        high_reg <= SRST ? 16'h0000 : high_next;
        oe_reg <= SRST ? 16'h0000 : oe_next;
    end
    drain_zero_a: assert property (DQ_OUT == 1'b0)
        else $error("line driven high");
    cmd_pulse_a: assert property (CMD_VALID |=> !CMD_VALID)
        else $error("command strobe too long");
    rx_pulse_a: assert property (RX_VALID |=> !RX_VALID)
        else $error("byte strobe too long");
    // the strobe trails the raw line by the synchroniser, so look a few cycles back
    reset_len_a: assert property (LINK_RESET
        |-> low_reg >= 16'h4B00 || $past(low_reg, 4) >= 16'h4B00)
        else $error("reset seen on short low");
    pres_wait_a: assert property ($rose(DQ_OE) && high_reg != 16'h0000
        |-> high_reg >= 16'h0258 && high_reg <= 16'h0960) else $error("presence wait off");
    read_start_a: assert property ($rose(DQ_OE) && high_reg == 16'h0000
        |-> low_reg <= 16'h0008) else $error("read drive late");
    drive_len_a: assert property ($fell(DQ_OE)
        |-> oe_reg >= 16'h0254 && oe_reg <= 16'h2580) else $error("drive length off");
    drive_bound_a: assert property (oe_reg <= 16'h2580)
        else $error("line never released");
endmodule : swl_link_checker
bind swl_link swl_link_checker i_swl_link_checker (.CORE_CLK(CORE_CLK), .SRST(SRST),
    .DQ_IN(DQ_IN), .DQ_OUT(DQ_OUT), .DQ_OE(DQ_OE), .RX_VALID(RX_VALID),
    .CMD_VALID(CMD_VALID), .LINK_RESET(LINK_RESET));

// *** verif/swl_master.sv ***
// behavioural bus master driving the open-drain line
// assumes calls start just after a rising clock edge
`timescale 1ns/1ps
module swl_master (
    input wire logic clk,
    input wire logic dq,
    output logic pull_low
);
    initial pull_low = 1'b0;
    task automatic hold(input bit low, input int n);
        pull_low <= low;
        repeat (n) @(posedge clk);
    endtask : hold
    task automatic line_reset(output int gap, output int len);
        gap = 0;
        len = 0;
        hold(1'b1, 19300);
        hold(1'b0, 0);
        for (int i = 0; i < 3200; i++) begin
            @(posedge clk);
            if (dq === 1'b0) len++;
            else if (len == 0) gap++;
        end
    endtask : line_reset
    // one short low for a one, whole slot for a zero
    task automatic wbit(input bit b);
        hold(1'b1, b ? 40 : 2400);
        hold(1'b0, b ? 2400 : 40);
    endtask : wbit
    task automatic wbyte(input logic [7:0] v);
        for (int i = 0; i < 8; i++) wbit(v[i]);
    endtask : wbyte
    // sample at 12 us: late but inside the validity period
    task automatic rbit(output logic b);
        hold(1'b1, 40);
        hold(1'b0, 440);
        b = dq;
        hold(1'b0, 1960);
    endtask : rbit
    task automatic rbyte(output logic [7:0] v);
        logic b;
        for (int i = 0; i < 8; i++) begin
            rbit(b);
            v[i] = b;
        end
    endtask : rbyte
endmodule : swl_master

// *** verif/tb_top.sv ***
// self-checking bench: sensor engine against a behavioural master
// assumes the pull-up wins whenever nobody pulls the line low
`timescale 1ns/1ps
module tb_top;
    import swl_pkg::*;
    typedef struct {logic busy; logic exp;} swl_row_t;
    logic CORE_CLK, SRST, PARASITE, OP_BUSY, DQ_OUT, DQ_OE, TX_NEXT, RX_VALID;
    logic CMD_VALID, LINK_RESET, m_low, dq_line, b;
    logic [7:0] TX_BYTE, RX_BYTE, CMD_BYTE, rx_last, cmd_last, rd;
    int errors, compares, cycles, cmd_n, rx_n, rst_n, tx_n, gap, len;
    swl_row_t rows [3] = '{'{1'b1, 1'b0}, '{1'b1, 1'b0}, '{1'b0, 1'b1}};
    assign dq_line = !(m_low || DQ_OE);
    swl_link i_swl_link (.CORE_CLK(CORE_CLK), .SRST(SRST), .DQ_IN(dq_line), .DQ_OUT(DQ_OUT),
        .DQ_OE(DQ_OE), .PARASITE(PARASITE), .OP_BUSY(OP_BUSY), .TX_BYTE(TX_BYTE),
        .TX_NEXT(TX_NEXT), .RX_BYTE(RX_BYTE), .RX_VALID(RX_VALID), .CMD_BYTE(CMD_BYTE),
        .CMD_VALID(CMD_VALID), .LINK_RESET(LINK_RESET));
    swl_master i_swl_master (.clk(CORE_CLK), .dq(dq_line), .pull_low(m_low));
    initial begin
        CORE_CLK = 1'b0;
        forever #12.5 CORE_CLK = !CORE_CLK;
    end
    task automatic conclude();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : conclude
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic chk_rng(input string what, input int lo, input int hi, input int got);
        compares++;
        if (got < lo || got > hi) begin
            errors++;
            $display("BAD %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask : chk_rng
    always @(posedge CORE_CLK) begin
        cycles++;
        if (CMD_VALID === 1'b1) begin cmd_n++; cmd_last = CMD_BYTE; end
        if (RX_VALID === 1'b1) begin rx_n++; rx_last = RX_BYTE; end
        if (LINK_RESET === 1'b1) rst_n++;
        if (TX_NEXT === 1'b1) tx_n++;
        if (cycles == 120000) begin errors++; conclude(); end
    end
    initial begin
        SRST = 1'b1;
        PARASITE = 1'b0;
        OP_BUSY = 1'b0;
        TX_BYTE = 8'h00;
        repeat (8) @(posedge CORE_CLK);
        chk("oe_in_reset", 16'h0000, {15'h0000, DQ_OE});
        SRST <= 1'b0;
        TX_BYTE <= 8'hA5;
        repeat (3) @(posedge CORE_CLK);
        i_swl_master.line_reset(gap, len);
        chk_rng("reset_seen", 1, 200, rst_n);
        chk_rng("pres_gap", 600, 2400, gap);
        chk_rng("pres_len", 2400, 9600, len);
        i_swl_master.wbyte(CMD_READ_SCRATCH);
        chk("cmd_byte", {8'h00, CMD_READ_SCRATCH}, {8'h00, cmd_last});
        chk("cmd_count", 16'h0001, 16'(cmd_n));
        i_swl_master.rbyte(rd);
        chk("read_byte", 16'h00A5, {8'h00, rd});
        chk("rx_echo", 16'h00A5, {8'h00, rx_last});
        chk_rng("tx_loads", 1, 2, tx_n);
        i_swl_master.line_reset(gap, len);
        chk_rng("pres_gap2", 600, 2400, gap);
        i_swl_master.wbyte(CMD_CONVERT);
        chk("cmd_conv", {8'h00, CMD_CONVERT}, {8'h00, cmd_last});
        foreach (rows[i]) begin
            OP_BUSY <= rows[i].busy;
            i_swl_master.rbit(b);
            chk("status_bit", {15'h0000, rows[i].exp}, {15'h0000, b});
        end
        chk("rx_count", 16'h0001, 16'(rx_n));
        conclude();
    end
endmodule : tb_top
